// file: rtl/mtl_pkg.sv
// Shared constants and types for the tone, line and handshake register bank.
// Assumes a single device clock that both register buses are synchronous to.
package mtl_pkg;

  // Modem-bus register addresses
  localparam logic [2:0] MTL_MA_TONE = 3'h3;
  localparam logic [2:0] MTL_MA_LINE = 3'h5;
  localparam logic [2:0] MTL_MA_SCR  = 3'h6;
  localparam logic [2:0] MTL_MA_HSK  = 3'h7;

  // UART-bus register addresses
  localparam logic [3:0] MTL_UA_TONE = 4'hb;
  localparam logic [3:0] MTL_UA_LINE = 4'hd;
  localparam logic [3:0] MTL_UA_SCR  = 4'he;
  localparam logic [3:0] MTL_UA_HSK  = 4'hf;

  // Tone transmit control fields
  localparam int MTL_TONE_FSEL  = 0;
  localparam int MTL_TONE_DTMF  = 4;
  localparam int MTL_TONE_ANS   = 5;
  localparam int MTL_TONE_GUARD = 6;
  localparam int MTL_TONE_ROUTE = 7;

  // Line hook and speaker control fields
  localparam int         MTL_LINE_HOOK  = 5;
  localparam int         MTL_LINE_SPK   = 6;
  localparam logic [7:0] MTL_LINE_MASK  = 8'he0;

  // Handshake fields
  localparam int MTL_HSK_DTR   = 4;
  localparam int MTL_HSK_RTS   = 5;
  localparam int MTL_HSK_TX_BIT_CLOCK = 7;

  // Idle serial line level
  localparam logic MTL_MARK = 1'b1;

  typedef enum logic [1:0] {
    MTL_SPK_OFF,
    MTL_SPK_M24DB,
    MTL_SPK_M12DB,
    MTL_SPK_0DB
  } mtl_spk_e;

  typedef enum logic [2:0] {
    MTL_SRC_NONE,
    MTL_SRC_DTMF,
    MTL_SRC_ANSWER,
    MTL_SRC_FSK,
    MTL_SRC_GUARD
  } mtl_src_e;

  typedef enum logic [2:0] {
    MTL_REG_NONE,
    MTL_REG_TONE,
    MTL_REG_LINE,
    MTL_REG_SCR,
    MTL_REG_HSK
  } mtl_reg_e;

  // One register bus: strobes, address and write data
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mtl_bus_s;

  // Transmit tone selection handed to the tone generators
  typedef struct packed {
    mtl_src_e   src;
    logic       ans2100;
    logic       guard550;
    logic [3:0] dtmfCode;
  } mtl_tone_s;

  // Pin and UART serial routing
  typedef struct packed {
    logic rxdPinOut;
    logic rxdPinOe;
    logic txdPin;
    logic uartRxIn;
  } mtl_route_s;

  typedef struct packed {
    logic [7:0] tone;
    logic [7:0] line;
    logic [7:0] scratch;
    logic [3:0] hsk;
    logic [7:0] mRdData;
    logic       mRdValid;
    logic [7:0] uRdData;
    logic       uRdValid;
    logic [3:0] msr;
    mtl_spk_e   spk;
  } mtl_regs_s;

  localparam mtl_regs_s  MTL_REGS_RST  = '0;
  localparam mtl_tone_s  MTL_TONE_RST  = '0;
  localparam mtl_route_s MTL_ROUTE_RST = '{rxdPinOut: MTL_MARK, rxdPinOe: 1'b0,
                                           txdPin: MTL_MARK, uartRxIn: MTL_MARK};

endpackage

// file: rtl/mtl_tone_arbiter.sv
// Picks the single transmit source from the tone control byte.
// Assumes transmit enable, answer mode and FSK request are synchronous levels.
`timescale 1ns/1ps
module mtl_tone_arbiter (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [7:0]        toneReg,
  input  wire logic              txEnable,
  input  wire logic              answerMode,
  input  wire logic              fskRequest,
  output mtl_pkg::mtl_tone_s     toneSel
);

  mtl_pkg::mtl_tone_s s_r;
  mtl_pkg::mtl_tone_s s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.ans2100  = toneReg[mtl_pkg::MTL_TONE_FSEL];
    s_nxt.guard550 = toneReg[mtl_pkg::MTL_TONE_FSEL];
    s_nxt.dtmfCode = toneReg[3:0];
    if (!txEnable) begin
      s_nxt.src = mtl_pkg::MTL_SRC_NONE;
    end else if (toneReg[mtl_pkg::MTL_TONE_DTMF]) begin
      s_nxt.src = mtl_pkg::MTL_SRC_DTMF;
    end else if (toneReg[mtl_pkg::MTL_TONE_ANS] && answerMode) begin
      s_nxt.src = mtl_pkg::MTL_SRC_ANSWER;
    end else if (fskRequest) begin
      s_nxt.src = mtl_pkg::MTL_SRC_FSK;
    end else if (toneReg[mtl_pkg::MTL_TONE_GUARD]) begin
      s_nxt.src = mtl_pkg::MTL_SRC_GUARD;
    end else begin
      s_nxt.src = mtl_pkg::MTL_SRC_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= mtl_pkg::MTL_TONE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign toneSel = s_r;

  a_tx_gate_off: assert property (@(posedge clock) disable iff (!rst_n)
    !txEnable |=> toneSel.src == mtl_pkg::MTL_SRC_NONE)
    else $error("tone emitted without transmit enable");
  a_dtmf_wins_all: assert property (@(posedge clock) disable iff (!rst_n)
    txEnable && toneReg[4] |=> toneSel.src == mtl_pkg::MTL_SRC_DTMF
                               && toneSel.dtmfCode == $past(toneReg[3:0]))
    else $error("dtmf not given precedence");
  a_answer_freq: assert property (@(posedge clock) disable iff (!rst_n)
    txEnable && !toneReg[4] && toneReg[5] && answerMode
      |=> toneSel.src == mtl_pkg::MTL_SRC_ANSWER && toneSel.ans2100 == $past(toneReg[0]))
    else $error("answer tone or its frequency wrong");
  a_answer_off: assert property (@(posedge clock) disable iff (!rst_n)
    !toneReg[5] |=> toneSel.src != mtl_pkg::MTL_SRC_ANSWER)
    else $error("answer tone without its enable");
  a_guard_last: assert property (@(posedge clock) disable iff (!rst_n)
    txEnable && toneReg[6:4] == 3'h4 && !fskRequest
      |=> toneSel.src == mtl_pkg::MTL_SRC_GUARD && toneSel.guard550 == $past(toneReg[0]))
    else $error("guard tone not selected");
  c_fsk_over_guard: cover property (@(posedge clock) disable iff (!rst_n)
    txEnable && fskRequest && toneReg[6] ##1 toneSel.src == mtl_pkg::MTL_SRC_FSK);

endmodule

// file: rtl/mtl_serial_route.sv
// Steers the receive and transmit data pins by the standalone pin and routing bit.
// Assumes all serial levels are synchronous to the device clock.
`timescale 1ns/1ps
module mtl_serial_route (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          standaloneSelectPin,
  input  wire logic          routeBit,
  input  wire logic          modemRxData,
  input  wire logic          uartSerialOut,
  input  wire logic          rxdPinIn,
  output mtl_pkg::mtl_route_s route
);

  mtl_pkg::mtl_route_s s_r;
  mtl_pkg::mtl_route_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!standaloneSelectPin) begin
      s_nxt.rxdPinOe  = 1'b1;
      s_nxt.rxdPinOut = modemRxData;
      s_nxt.txdPin    = uartSerialOut;
      s_nxt.uartRxIn  = modemRxData;
    end else if (!routeBit) begin
      s_nxt.rxdPinOe  = 1'b0;
      s_nxt.rxdPinOut = mtl_pkg::MTL_MARK;
      s_nxt.txdPin    = mtl_pkg::MTL_MARK;
      s_nxt.uartRxIn  = modemRxData;
    end else begin
      s_nxt.rxdPinOe  = 1'b0;
      s_nxt.rxdPinOut = mtl_pkg::MTL_MARK;
      s_nxt.txdPin    = uartSerialOut;
      s_nxt.uartRxIn  = rxdPinIn;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= mtl_pkg::MTL_ROUTE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign route = s_r;

  a_monitor_mode: assert property (@(posedge clock) disable iff (!rst_n)
    !standaloneSelectPin |=> route.rxdPinOe && route.rxdPinOut == $past(modemRxData)
                             && route.txdPin == $past(uartSerialOut))
    else $error("monitor routing wrong");
  a_forced_mark: assert property (@(posedge clock) disable iff (!rst_n)
    standaloneSelectPin && !routeBit |=> !route.rxdPinOe && route.txdPin == 1'b1)
    else $error("transmit pin not held at mark");
  a_uart_routed: assert property (@(posedge clock) disable iff (!rst_n)
    standaloneSelectPin && routeBit |=> !route.rxdPinOe
      && route.uartRxIn == $past(rxdPinIn) && route.txdPin == $past(uartSerialOut))
    else $error("standalone uart routing wrong");
  c_standalone_uart: cover property (@(posedge clock) disable iff (!rst_n)
    standaloneSelectPin && routeBit ##1 route.uartRxIn == 1'b0);

endmodule

// file: rtl/mtl_tone_line_regs.sv
// Dual-bus register bank: tone control, line hook and speaker, scratch, handshake.
// Assumes both buses share the device clock; a modem-bus write wins a same-cycle clash.
//
// How it works
// - Tone-pair enable bit 4 sends the DTMF pair ahead of everything else.
// - Answer enable with bit 0 clear sends 2225 Hz while transmitting, answer mode.
// - Answer enable with bit 0 set sends 2100 Hz, otherwise identical.
// - Answer enable clear keeps the answer tone off whatever bit 0 holds.
// - Bit 6 turns the guard tone on; bit 0 picks its frequency.
// - Standalone pin low: modem data drives receive pin, UART output on transmit pin.
// - Standalone high, routing clear: receive pin ignored, transmit pin held at mark.
// - Standalone high, routing set: receive pin feeds UART, UART drives transmit pin.
// - Line register sits at modem address 5, UART address 13; bits 0-4 unused.
// - Line bit 5 set pulls the open-drain hook driver low; clear leaves it open.
// - Line bits 7:6 give speaker off, -24 dB, -12 dB or 0 dB.
// - One scratch register at modem 6 and UART 14, read-write from both.
// - Handshake register sits at modem 7 and UART 15; bit 6 unused.
// - Dual-port: local processor writes bits 0-3, host sees them as modem status.
// - Single-port: bits 0-3 ignored, modem status taken from external pins.
// - Handshake bits 4 and 5 mirror host DTR and RTS, read only.
// - Handshake bit 7 mirrors the UART transmit bit clock.
// - Tones go out only while transmit enable is set.
// - Source order: DTMF, answer tone, FSK data, guard tone.
`timescale 1ns/1ps
module mtl_tone_line_regs (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  mtl_pkg::mtl_bus_s       modemBus,
  input  mtl_pkg::mtl_bus_s       uartBus,
  output logic [7:0]              modemRdData,
  output logic                    modemRdValid,
  output logic [7:0]              uartRdData,
  output logic                    uartRdValid,
  input  wire logic               txEnable,
  input  wire logic               answerMode,
  input  wire logic               fskRequest,
  output mtl_pkg::mtl_tone_s      toneSel,
  input  wire logic               standaloneSelectPin,
  input  wire logic               modemRxData,
  input  wire logic               uartSerialOut,
  input  wire logic               rxdPinIn,
  output logic                    rxdPinOut,
  output logic                    rxdPinOe,
  output logic                    txdPin,
  output logic                    uartSerialIn,
  output logic                    hookPinOut,
  output logic                    hookPinOe,
  output mtl_pkg::mtl_spk_e       speakerLevel,
  input  wire logic               dualPortMode,
  input  wire logic [3:0]         extModemStatus,
  input  wire logic               hostDtr,
  input  wire logic               hostRts,
  input  wire logic               txBitClock,
  output logic [3:0]              modemStatus
);

  mtl_pkg::mtl_regs_s  s_r;
  mtl_pkg::mtl_regs_s  s_nxt;
  mtl_pkg::mtl_reg_e   mSel;
  mtl_pkg::mtl_reg_e   uSel;
  mtl_pkg::mtl_route_s route;

  function automatic mtl_pkg::mtl_reg_e decodeModem(input logic [2:0] a);
    if (a == mtl_pkg::MTL_MA_TONE) begin
      return mtl_pkg::MTL_REG_TONE;
    end else if (a == mtl_pkg::MTL_MA_LINE) begin
      return mtl_pkg::MTL_REG_LINE;
    end else if (a == mtl_pkg::MTL_MA_SCR) begin
      return mtl_pkg::MTL_REG_SCR;
    end else if (a == mtl_pkg::MTL_MA_HSK) begin
      return mtl_pkg::MTL_REG_HSK;
    end else begin
      return mtl_pkg::MTL_REG_NONE;
    end
  endfunction

  function automatic mtl_pkg::mtl_reg_e decodeUart(input logic [3:0] a);
    if (a == mtl_pkg::MTL_UA_TONE) begin
      return mtl_pkg::MTL_REG_TONE;
    end else if (a == mtl_pkg::MTL_UA_LINE) begin
      return mtl_pkg::MTL_REG_LINE;
    end else if (a == mtl_pkg::MTL_UA_SCR) begin
      return mtl_pkg::MTL_REG_SCR;
    end else if (a == mtl_pkg::MTL_UA_HSK) begin
      return mtl_pkg::MTL_REG_HSK;
    end else begin
      return mtl_pkg::MTL_REG_NONE;
    end
  endfunction

  // Addresses outside this bank belong to other register groups and read as zero here
  function automatic logic [7:0] readView(input mtl_pkg::mtl_reg_e r,
                                          input mtl_pkg::mtl_regs_s s);
    if (r == mtl_pkg::MTL_REG_TONE) begin
      return s.tone;
    end else if (r == mtl_pkg::MTL_REG_LINE) begin
      return s.line & mtl_pkg::MTL_LINE_MASK;
    end else if (r == mtl_pkg::MTL_REG_SCR) begin
      return s.scratch;
    end else if (r == mtl_pkg::MTL_REG_HSK) begin
      return {txBitClock, 1'b0, hostRts, hostDtr, s.hsk};
    end else begin
      return 8'h00;
    end
  endfunction

  function automatic mtl_pkg::mtl_regs_s applyWrite(input mtl_pkg::mtl_regs_s s,
                                                    input mtl_pkg::mtl_reg_e r,
                                                    input logic [7:0] d);
    mtl_pkg::mtl_regs_s t;
    t = s;
    if (r == mtl_pkg::MTL_REG_TONE) begin
      t.tone = d;
    end else if (r == mtl_pkg::MTL_REG_LINE) begin
      t.line = d & mtl_pkg::MTL_LINE_MASK;
      t.spk  = mtl_pkg::mtl_spk_e'(d[mtl_pkg::MTL_LINE_SPK +: 2]);
    end else if (r == mtl_pkg::MTL_REG_SCR) begin
      t.scratch = d;
    end else if (r == mtl_pkg::MTL_REG_HSK) begin
      t.hsk = d[3:0];
    end
    return t;
  endfunction

  always_comb begin
    mSel = decodeModem(modemBus.addr[2:0]);
    uSel = decodeUart(uartBus.addr);
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.mRdValid = modemBus.rd;
    s_nxt.uRdValid = uartBus.rd;
    if (modemBus.rd) begin
      s_nxt.mRdData = readView(mSel, s_r);
    end
    if (uartBus.rd) begin
      s_nxt.uRdData = readView(uSel, s_r);
    end
    // Modem write applied last so it wins a clash on the same register
    if (uartBus.wr) begin
      s_nxt = applyWrite(s_nxt, uSel, uartBus.wdata);
    end
    if (modemBus.wr) begin
      s_nxt = applyWrite(s_nxt, mSel, modemBus.wdata);
    end
    // Stored bits stay readable in single-port mode even though they are not used
    if (dualPortMode) begin
      s_nxt.msr = s_r.hsk;
    end else begin
      s_nxt.msr = extModemStatus;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= mtl_pkg::MTL_REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  mtl_tone_arbiter u_tone (
    .clock      (clock),
    .rst_n      (rst_n),
    .toneReg    (s_r.tone),
    .txEnable   (txEnable),
    .answerMode (answerMode),
    .fskRequest (fskRequest),
    .toneSel    (toneSel)
  );

  mtl_serial_route u_route (
    .clock               (clock),
    .rst_n               (rst_n),
    .standaloneSelectPin (standaloneSelectPin),
    .routeBit            (s_r.tone[mtl_pkg::MTL_TONE_ROUTE]),
    .modemRxData         (modemRxData),
    .uartSerialOut       (uartSerialOut),
    .rxdPinIn            (rxdPinIn),
    .route               (route)
  );

  assign modemRdData  = s_r.mRdData;
  assign modemRdValid = s_r.mRdValid;
  assign uartRdData   = s_r.uRdData;
  assign uartRdValid  = s_r.uRdValid;
  assign rxdPinOut    = route.rxdPinOut;
  assign rxdPinOe     = route.rxdPinOe;
  assign txdPin       = route.txdPin;
  assign uartSerialIn = route.uartRxIn;
  // Open drain: only ever pulls low, never drives high
  assign hookPinOut   = 1'b0;
  assign hookPinOe    = s_r.line[mtl_pkg::MTL_LINE_HOOK];
  assign speakerLevel = s_r.spk;
  assign modemStatus  = s_r.msr;

  a_line_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.rd && modemBus.addr[2:0] == 3'h5 |=> modemRdValid && modemRdData[4:0] == 5'h00)
    else $error("unused line bits read nonzero");
  a_hook_pull: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.wr && !modemBus.wr && uartBus.addr == 4'hd
      |=> hookPinOe == $past(uartBus.wdata[5]) && hookPinOut == 1'b0)
    else $error("hook driver does not follow bit 5");
  a_spk_level: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.wr && modemBus.addr[2:0] == 3'h5 |=> speakerLevel == $past(modemBus.wdata[7:6]))
    else $error("speaker level wrong");
  a_scr_shared: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.wr && uartBus.addr == 4'he && !(modemBus.wr && modemBus.addr[2:0] == 3'h6)
      ##1 modemBus.rd && modemBus.addr[2:0] == 3'h6 && !uartBus.wr && !modemBus.wr
      |=> modemRdData == $past(uartBus.wdata, 2))
    else $error("scratch not shared across buses");
  a_hsk_mirror: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.rd && uartBus.addr == 4'hf
      |=> uartRdData[6:4] == {1'b0, $past(hostRts), $past(hostDtr)})
    else $error("handshake mirror bits wrong");
  a_tx_bit_clock_view: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.rd && modemBus.addr[2:0] == 3'h7 |=> modemRdData[7] == $past(txBitClock))
    else $error("bit clock not reflected");
  a_msr_dual: assert property (@(posedge clock) disable iff (!rst_n)
    dualPortMode && modemBus.wr && modemBus.addr[2:0] == 3'h7 && !uartBus.wr
      ##1 dualPortMode |=> modemStatus == $past(modemBus.wdata[3:0], 2))
    else $error("local status not passed to host");
  a_msr_single: assert property (@(posedge clock) disable iff (!rst_n)
    !dualPortMode |=> modemStatus == $past(extModemStatus))
    else $error("single-port status not from pins");
  c_both_write: cover property (@(posedge clock) disable iff (!rst_n)
    modemBus.wr && uartBus.wr && mSel == uSel && mSel != mtl_pkg::MTL_REG_NONE);
  c_hook_on: cover property (@(posedge clock) disable iff (!rst_n) $rose(hookPinOe));
  c_dual_status: cover property (@(posedge clock) disable iff (!rst_n)
    dualPortMode && modemStatus != 4'h0);

  // Read handshake on both buses: valid pulses once, data stands until the next read
  a_mvalid_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> modemRdValid == $past(modemBus.rd))
    else $error("modem read valid not a one-cycle answer");

  a_uvalid_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> uartRdValid == $past(uartBus.rd))
    else $error("uart read valid not a one-cycle answer");

  a_mdata_stands: assert property (@(posedge clock) disable iff (!rst_n)
    !modemBus.rd |=> $stable(modemRdData))
    else $error("modem read data changed without a read");

  a_udata_stands: assert property (@(posedge clock) disable iff (!rst_n)
    !uartBus.rd |=> $stable(uartRdData))
    else $error("uart read data changed without a read");

  // Addresses of other register groups read as zero from this bank
  a_u_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.rd && uartBus.addr < 4'hb |=> uartRdData == 8'h00)
    else $error("unmapped uart address read nonzero");

  a_m_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.rd && (modemBus.addr[2:0] < 3'h3 || modemBus.addr[2:0] == 3'h4)
      |=> modemRdData == 8'h00)
    else $error("unmapped modem address read nonzero");

  a_line_view_m: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.rd && modemBus.addr[2:0] == 3'h5
      |=> modemRdData[7:5] == $past({speakerLevel, hookPinOe}))
    else $error("modem line read disagrees with pins");

  a_line_view_u: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.rd && uartBus.addr == 4'hd
      |=> uartRdData == {$past({speakerLevel, hookPinOe}), 5'h00})
    else $error("uart line read disagrees with pins");

  a_hsk_mid_m: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.rd && modemBus.addr[2:0] == 3'h7
      |=> modemRdData[6:4] == {1'b0, $past(hostRts), $past(hostDtr)})
    else $error("modem handshake mirror bits wrong");

  a_tx_bit_clock_uart: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.rd && uartBus.addr == 4'hf |=> uartRdData[7] == $past(txBitClock))
    else $error("bit clock not reflected to host");

  a_hook_never_high: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |-> hookPinOut == 1'b0)
    else $error("hook driver drives high");

  a_hook_modem: assert property (@(posedge clock) disable iff (!rst_n)
    modemBus.wr && modemBus.addr[2:0] == 3'h5 |=> hookPinOe == $past(modemBus.wdata[5]))
    else $error("hook driver ignores modem write");

  a_spk_uart: assert property (@(posedge clock) disable iff (!rst_n)
    uartBus.wr && uartBus.addr == 4'hd && !(modemBus.wr && modemBus.addr[2:0] == 3'h5)
      |=> speakerLevel == $past(uartBus.wdata[7:6]))
    else $error("speaker level ignores uart write");

endmodule

// file: sim/mtl_host_model.sv
// Far-side model: host UART transmitter giving the bit clock and serial output.
// Assumes the bench starts and stops it with run; the clock stands still when stopped.
`timescale 1ns/1ps
module mtl_host_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic dataBit,
  output logic      txBitClock,
  output logic      serialOut
);
  logic [1:0] div;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div        <= 2'h0;
      txBitClock <= 1'b0;
      serialOut  <= 1'b1;
    end else begin
      if (run) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
          txBitClock <= !txBitClock;
        end
      end
      // While running, data changes only on the falling bit clock, so it is set up before each rise; stopped, it follows dataBit
      if (!run || (div == 2'h3 && txBitClock)) begin
        serialOut <= dataBit;
      end
    end
  end
endmodule

// file: sim/mtl_tone_line_regs_bench.sv
// Self-checking bench for the tone, line and handshake register bank.
// Assumes the design answers reads one cycle after the strobe edge.
`timescale 1ns/1ps
module mtl_tone_line_regs_bench;
  logic               clock = 1'b0;
  logic               rst_n = 1'b0;
  mtl_pkg::mtl_bus_s  modemBus = '0;
  mtl_pkg::mtl_bus_s  uartBus = '0;
  logic [7:0]         modemRdData, uartRdData;
  logic               modemRdValid, uartRdValid;
  logic               txEnable = 1'b0, answerMode = 1'b0, fskRequest = 1'b0;
  mtl_pkg::mtl_tone_s toneSel;
  logic               standaloneSelectPin = 1'b0, modemRxData = 1'b1, rxdPinIn = 1'b0;
  logic               uartSerialOut, rxdPinOut, rxdPinOe, txdPin, uartSerialIn;
  logic               hookPinOut, hookPinOe;
  mtl_pkg::mtl_spk_e  speakerLevel;
  logic               dualPortMode = 1'b1, hostDtr = 1'b0, hostRts = 1'b0;
  logic [3:0]         extModemStatus = 4'h5;
  logic               txBitClock, run = 1'b0, dataBit = 1'b0;
  logic [3:0]         modemStatus;
  int                 fails = 0, totalChecks = 0;
  logic [10:0]        toneTab [7];
  logic [3:0]         routeExp [3];

  always #2.5 clock = !clock;

  mtl_tone_line_regs u_mtl_tone_line_regs (.clock(clock), .rst_n(rst_n), .modemBus(modemBus),
    .uartBus(uartBus), .modemRdData(modemRdData), .modemRdValid(modemRdValid),
    .uartRdData(uartRdData), .uartRdValid(uartRdValid), .txEnable(txEnable),
    .answerMode(answerMode), .fskRequest(fskRequest), .toneSel(toneSel),
    .standaloneSelectPin(standaloneSelectPin), .modemRxData(modemRxData),
    .uartSerialOut(uartSerialOut), .rxdPinIn(rxdPinIn), .rxdPinOut(rxdPinOut),
    .rxdPinOe(rxdPinOe), .txdPin(txdPin), .uartSerialIn(uartSerialIn),
    .hookPinOut(hookPinOut), .hookPinOe(hookPinOe), .speakerLevel(speakerLevel),
    .dualPortMode(dualPortMode), .extModemStatus(extModemStatus), .hostDtr(hostDtr),
    .hostRts(hostRts), .txBitClock(txBitClock), .modemStatus(modemStatus));

  mtl_host_model u_mtl_host_model (.clock(clock), .rst_n(rst_n), .run(run),
    .dataBit(dataBit), .txBitClock(txBitClock), .serialOut(uartSerialOut));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Returns at the edge that takes the strobe
  task automatic busOp(input logic u, input logic w, input logic [3:0] a, input logic [7:0] d);
    mtl_pkg::mtl_bus_s b;
    b = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    if (u) uartBus <= b;
    else modemBus <= b;
    @(posedge clock);
    modemBus <= '0;
    uartBus <= '0;
  endtask

  task automatic rd(input logic u, input logic [3:0] a, input logic [7:0] exp);
    busOp(u, 1'b0, a, 8'h00);
    #1;
    chk({u ? uartRdValid : modemRdValid, u ? uartRdData : modemRdData}, {1'b1, exp});
  endtask

  function automatic mtl_pkg::mtl_tone_s expTone(input logic [10:0] v);
    mtl_pkg::mtl_tone_s t;
    t.ans2100 = v[3];
    t.guard550 = v[3];
    t.dtmfCode = v[6:3];
    if (!v[2]) t.src = mtl_pkg::MTL_SRC_NONE;
    else if (v[7]) t.src = mtl_pkg::MTL_SRC_DTMF;
    else if (v[8] && v[1]) t.src = mtl_pkg::MTL_SRC_ANSWER;
    else if (v[0]) t.src = mtl_pkg::MTL_SRC_FSK;
    else if (v[9]) t.src = mtl_pkg::MTL_SRC_GUARD;
    else t.src = mtl_pkg::MTL_SRC_NONE;
    return t;
  endfunction

  task automatic finish_test();
    if (fails == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #25000;
    fails++;
    finish_test();
  end

  initial begin
    // Rows are {tone byte, transmit enable, answer mode, FSK request}
    toneTab = '{{8'h7f, 3'h7}, {8'h61, 3'h7}, {8'h60, 3'h6}, {8'h61, 3'h5},
                {8'h41, 3'h6}, {8'h21, 3'h3}, {8'h01, 3'h6}};
    routeExp = '{4'hd, 4'h3, 4'h0};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd(1'b0, 4'h5, 8'h00);
    rd(1'b1, 4'he, 8'h00);
    rd(1'b0, 4'h7, 8'h00);
    busOp(1'b0, 1'b1, 4'h6, 8'ha5);
    rd(1'b1, 4'he, 8'ha5);
    busOp(1'b1, 1'b1, 4'he, 8'h3c);
    rd(1'b0, 4'h6, 8'h3c);
    rd(1'b1, 4'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      busOp(1'b1, 1'b1, 4'hd, {i[1:0], 6'h3f});
      #1;
      chk({speakerLevel, hookPinOe, hookPinOut}, {i[1:0], 2'b10});
      rd(1'b0, 4'h5, {i[1:0], 6'h20});
    end
    busOp(1'b0, 1'b1, 4'h5, 8'h00);
    #1;
    chk({speakerLevel, hookPinOe}, 3'h0);
    hostDtr <= 1'b1;
    busOp(1'b0, 1'b1, 4'h7, 8'hff);
    rd(1'b0, 4'h7, 8'h1f);
    #1;
    chk(modemStatus, 4'hf);
    dualPortMode <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(modemStatus, 4'h5);
    hostDtr <= 1'b0;
    hostRts <= 1'b1;
    rd(1'b1, 4'hf, 8'h2f);
    run <= 1'b1;
    for (int n = 0; n < 20 && txBitClock !== 1'b1; n++) @(posedge clock);
    run <= 1'b0;
    rd(1'b0, 4'h7, 8'haf);
    foreach (toneTab[k]) begin
      busOp(1'b0, 1'b1, 4'h3, toneTab[k][10:3]);
      {txEnable, answerMode, fskRequest} <= toneTab[k][2:0];
      repeat (2) @(posedge clock);
      #1;
      // Rows cover every source, both answer tones, the guard tone with bit 0 set and both blockers
      chk(toneSel, expTone(toneTab[k]));
    end
    foreach (routeExp[k]) begin
      busOp(1'b1, 1'b1, 4'hb, k == 1 ? 8'h00 : 8'h80);
      standaloneSelectPin <= (k != 0);
      repeat (2) @(posedge clock);
      #1;
      chk({rxdPinOe, rxdPinOe ? rxdPinOut : 1'b0, txdPin, uartSerialIn}, routeExp[k]);
    end
    finish_test();
  end
endmodule
